/* File: bench/dof_properties.sv */
// checker on the output stage ports
`default_nettype none
module dof_chk #(
	parameter int ERR_W = 8,
	parameter int DATA_W = 10
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_B_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [31:0] REG_RDATA_O,
	input wire logic [ERR_W-1:0] ERR_EVENT_I,
	input wire logic FRAME_START_I,
	input wire logic LOCKED_I,
	input wire logic [DATA_W-1:0] DOUT_O,
	input wire logic PCLK_O,
	input wire logic ERROR_FLAG_B_O,
	input wire logic [3:0] STAT_O,
	input wire logic BUFFER_LOAD_FLAG_O
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [ERR_W-1:0] mask_ff;
	logic [1:0] mode_ff;
	logic [4:0] clr_ff, ev_ff;
	logic [3:0] run_ff, ok_ff;
	logic pq_ff;
	wire logic mw = REG_WR_I && REG_ADDR_I == dof_pkg::ERR_MASK_ADDR;
	wire logic ev = |(ERR_EVENT_I & mask_ff);
	wire logic clr = mw || FRAME_START_I || !LOCKED_I ||
		(REG_RD_I && REG_ADDR_I == dof_pkg::ERR_STATUS_ADDR);
	// ----
	// ages saturate so idle runs stay quiet
	// ----
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			mask_ff <= dof_pkg::ERR_MASK_RST[ERR_W-1:0];
			mode_ff <= 2'h0;
			clr_ff <= 5'h0;
			ev_ff <= 5'h1f;
			run_ff <= 4'h0;
			ok_ff <= 4'h0;
			pq_ff <= 1'b0;
		end else begin
			if (mw) begin
				mask_ff <= REG_WDATA_I[ERR_W-1:0];
			end
			if (REG_WR_I && REG_ADDR_I == dof_pkg::BUF_CTRL_ADDR) begin
				mode_ff <= REG_WDATA_I[1:0];
			end
			clr_ff <= clr ? 5'h0 : clr_ff + 5'(clr_ff != 5'h1f);
			ev_ff <= (ev || mw || !LOCKED_I) ? 5'h0 : ev_ff + 5'(ev_ff != 5'h1f);
			pq_ff <= PCLK_O;
			run_ff <= (PCLK_O != pq_ff) ? 4'h0 : run_ff + 4'(run_ff != 4'hf);
			ok_ff <= (!LOCKED_I || REG_WR_I) ? 4'h0 : ok_ff + 4'(ok_ff != 4'hf);
		end
	end
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_B_I);
	AST_LOCK_ZERO: assert property (!LOCKED_I && $past(!LOCKED_I) && $past(!LOCKED_I, 2)
		|-> DOUT_O == '0 && STAT_O == 4'h0 && !BUFFER_LOAD_FLAG_O)
		else $error("outputs not low while unlocked");
	AST_FLAG_SETS: assert property (ev && LOCKED_I |-> ##[1:10] (!ERROR_FLAG_B_O || clr))
		else $error("masked error did not pull flag low");
	AST_FLAG_HOLDS: assert property ($rose(ERROR_FLAG_B_O) |-> clr_ff < 5'd16)
		else $error("flag released without read or frame start");
	AST_FLAG_CAUSE: assert property ($fell(ERROR_FLAG_B_O) |-> ev_ff < 5'd12)
		else $error("flag low without a masked error");
	AST_UNMAPPED: assert property (REG_RD_I && REG_ADDR_I > dof_pkg::STATUS_ADDR
		|=> REG_RDATA_O == 32'h0)
		else $error("unmapped read not zero");
	AST_MASK_BACK: assert property (REG_RD_I && REG_ADDR_I == dof_pkg::ERR_MASK_ADDR
		|=> REG_RDATA_O[ERR_W-1:0] == $past(mask_ff))
		else $error("mask read back wrong");
	AST_PCLK_RATE: assert property (ok_ff == 4'hf |-> run_ff < 4'h3)
		else $error("pixel clock half period too long");
	AST_BYPASS_DOUT: assert property (mode_ff == 2'h0 && ok_ff == 4'hf && $changed(DOUT_O)
		|-> $rose(PCLK_O) || $past(PCLK_O) && !$past(PCLK_O, 2))
		else $error("bypass data moved off pixel clock rise");
	COV_FLAG: cover property ($fell(ERROR_FLAG_B_O));
	COV_LOAD: cover property (BUFFER_LOAD_FLAG_O);
	COV_UNLOCK: cover property (!LOCKED_I);
endmodule
`default_nettype wire

/* File: bench/dof_reader.sv */
// behavioural downstream reader of the parallel bus
`default_nettype none
module dof_reader (
	input wire logic [9:0] dout_i,
	output logic rd_clk_o,
	output logic rd_reset_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] q[$];
	initial begin
		rd_clk_o = 1'b0;
		rd_reset_o = 1'b0;
	end
	task automatic read(input int n);
		q.delete();
		#3;
		repeat (n) begin
			rd_clk_o = 1'b1;
			#40;
			rd_clk_o = 1'b0;
			#40;
			q.push_back(dout_i);
		end
	endtask
	task automatic rst_ptr();
		rd_reset_o = 1'b1;
		#160;
		rd_reset_o = 1'b0;
		#160;
	endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench for the output stage
`default_nettype none
`define CHK(a, b) begin \
	checks++; \
	if ((a) !== (b)) begin \
		bad_count++; \
		$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
	end \
end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_b, wr, rd, fs, lock, wv, h, v, f, anc, cpk, hso, tdo, ssel, sin, vmi, smode;
	logic [7:0] addr, ev;
	logic [31:0] wdata, rdata;
	logic [9:0] word, dout;
	logic [3:0] stat;
	logic pclk, flag_b, ldf, sout, soe, hsdin, tdi, rdclk, rdrst;
	logic ld_seen = 1'b0;
	int bad_count, checks;
	dof_output_stage dof_output_stage_i (.CLK_SYS_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .ERR_EVENT_I(ev),
		.FRAME_START_I(fs), .LOCKED_I(lock), .WORD_I(word), .WORD_VALID_I(wv), .H_I(h), .V_I(v),
		.F_I(f), .ANCILLARY_PACKET_SEEN_I(anc), .CHECK_PACKET_SEEN_I(cpk), .HOST_SDOUT_I(hso),
		.SCAN_TDO_I(tdo), .RD_CLK_I(rdclk), .RD_RESET_I(rdrst), .SCAN_SELECT_I(ssel),
		.SERIAL_IN_PIN_I(sin), .VIDEO_MODE_INDICATOR_I(vmi), .STREAM_MODE_I(smode),
		.DOUT_O(dout), .PCLK_O(pclk), .ERROR_FLAG_B_O(flag_b), .STAT_O(stat),
		.BUFFER_LOAD_FLAG_O(ldf), .SERIAL_OUT_PIN_O(sout), .SERIAL_OUT_PIN_OE_O(soe),
		.HOST_SDIN_O(hsdin), .SCAN_TDI_O(tdi));
	dof_reader dof_reader_i (.dout_i(dout), .rd_clk_o(rdclk), .rd_reset_o(rdrst));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (ldf === 1'b1) begin
			ld_seen <= 1'b1;
		end
	end
	// ----
	// bus and timing helpers
	// ----
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic pulse_ev(input logic [7:0] e);
		@(posedge clk);
		ev <= e;
		@(posedge clk);
		ev <= 8'h0;
	endtask
	task automatic rd_words(input int n, input int first);
		dof_reader_i.read(n);
		for (int i = 0; i < n; i++) begin
			`CHK(dof_reader_i.q[i], 10'h300 + 10'(first + i))
		end
	endtask
	task automatic results;
		if (bad_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_regs;
		logic [31:0] d;
		rd_reg(dof_pkg::ERR_MASK_ADDR, d);
		`CHK(d[7:0], 8'hff)
		rd_reg(dof_pkg::IO_CFG_ADDR, d);
		`CHK(d, dof_pkg::IO_CFG_RST)
		rd_reg(dof_pkg::BUF_CTRL_ADDR, d);
		`CHK(d[1:0], dof_pkg::BUF_CTRL_RST)
		rd_reg(8'h20, d);
		`CHK(d, 32'h0)
	endtask
	task automatic t_flag;
		logic [31:0] d;
		`CHK(flag_b, 1'b1)
		pulse_ev(8'h08);
		cyc(10);
		`CHK(flag_b, 1'b0)
		cyc(30);
		`CHK(flag_b, 1'b0)
		rd_reg(dof_pkg::ERR_STATUS_ADDR, d);
		`CHK(d[7:0], 8'h08)
		cyc(15);
		`CHK(flag_b, 1'b1)
		pulse_ev(8'h81);
		cyc(10);
		`CHK(flag_b, 1'b0)
		@(posedge clk);
		fs <= 1'b1;
		@(posedge clk);
		fs <= 1'b0;
		cyc(15);
		`CHK(flag_b, 1'b1)
	endtask
	task automatic t_mask;
		logic [31:0] d;
		wr_reg(dof_pkg::ERR_MASK_ADDR, 32'hfe);
		rd_reg(dof_pkg::ERR_MASK_ADDR, d);
		`CHK(d[7:0], 8'hfe)
		pulse_ev(8'h01);
		cyc(12);
		`CHK(flag_b, 1'b1)
		rd_reg(dof_pkg::ERR_STATUS_ADDR, d);
		wr_reg(dof_pkg::ERR_MASK_ADDR, 32'hff);
	endtask
	task automatic t_pclk;
		int n;
		logic p;
		n = 0;
		p = pclk;
		repeat (1000) begin
			@(negedge clk);
			n += int'(pclk && !p);
			p = pclk;
		end
		n -= dof_pkg::PIX_CLK_MHZ * 1000 / dof_pkg::SYS_CLK_MHZ;
		`CHK(n >= -1 && n <= 1, 1'b1)
	endtask
	task automatic t_bypass;
		logic [9:0] w[2] = '{10'h2a5, 10'h15a};
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			word <= w[i];
			wv <= 1'b1;
			@(posedge clk);
			wv <= 1'b0;
			cyc(8);
			`CHK(dout, w[i])
		end
	endtask
	task automatic t_stat;
		logic [7:0] tbl = 8'ha5;
		@(posedge clk);
		h <= 1'b1;
		f <= 1'b1;
		cpk <= 1'b1;
		cyc(8);
		`CHK(stat, 4'h5)
		for (int s = 0; s < 8; s++) begin
			wr_reg(dof_pkg::IO_CFG_ADDR, 32'h1000 | (32'(s) * 32'h249));
			cyc(8);
			`CHK(stat, {4{tbl[s]}})
		end
		wr_reg(dof_pkg::IO_CFG_ADDR, 32'h0);
		wr_reg(dof_pkg::BUF_CTRL_ADDR, 32'h2);
		cyc(8);
		`CHK(stat, 4'hc)
		wr_reg(dof_pkg::BUF_CTRL_ADDR, 32'h0);
	endtask
	task automatic t_buf;
		wr_reg(dof_pkg::BUF_CTRL_ADDR, 32'h1);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			word <= 10'h300 + 10'(i);
			wv <= 1'b1;
			@(posedge clk);
			wv <= 1'b0;
		end
		cyc(4);
		`CHK(ld_seen, 1'b1)
		rd_words(3, 0);
		dof_reader_i.rst_ptr();
		rd_words(2, 0);
		@(posedge clk);
		smode <= 1'b1;
		cyc(6);
		dof_reader_i.rst_ptr();
		rd_words(1, 2);
		@(posedge clk);
		smode <= 1'b0;
		wr_reg(dof_pkg::BUF_CTRL_ADDR, 32'h0);
	endtask
	task automatic t_serial;
		for (int s = 0; s < 2; s++) begin
			@(posedge clk);
			ssel <= s[0];
			hso <= ~s[0];
			tdo <= s[0];
			sin <= 1'b1;
			cyc(8);
			`CHK(sout, 1'b1)
			`CHK(soe, 1'b1)
			`CHK(hsdin, ~s[0])
			`CHK(tdi, s[0])
		end
	endtask
	task automatic t_lock;
		@(posedge clk);
		lock <= 1'b0;
		cyc(4);
		`CHK(stat, 4'h0)
		`CHK(dout, 10'h0)
		`CHK(flag_b, 1'b0)
		`CHK(pclk, 1'b0)
		@(posedge clk);
		lock <= 1'b1;
		cyc(20);
	endtask
	initial begin
		{wr, rd, fs, wv, h, v, f, anc, cpk, hso, tdo, ssel, sin, smode} = '0;
		{addr, ev, wdata, word} = '0;
		lock = 1'b1;
		vmi = 1'b1;
		rst_b = 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		cyc(3);
		t_regs();
		t_flag();
		t_mask();
		t_pclk();
		t_bypass();
		t_stat();
		t_buf();
		t_serial();
		t_lock();
		results();
	end
	// whole run is about 15 us
	initial begin
		#100000;
		bad_count++;
		results();
	end
endmodule
bind dof_output_stage dof_chk #(.ERR_W(ERR_W), .DATA_W(DATA_W)) dof_chk_i (.CLK_SYS_I,
	.RST_B_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .ERR_EVENT_I,
	.FRAME_START_I, .LOCKED_I, .DOUT_O, .PCLK_O, .ERROR_FLAG_B_O, .STAT_O, .BUFFER_LOAD_FLAG_O);
`default_nettype wire

/* File: src/dof_line_mem.sv */
// line buffer storage with registered read data
`default_nettype none
module dof_line_mem #(
	parameter int DATA_W = 10,
	parameter int ADDR_W = 10
) (
	input wire logic clk_i,
	dof_mem_if.mem port_i
);
	logic [DATA_W-1:0] mem_array [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] rd_data_ff;

	always_ff @(posedge clk_i) begin
		if (port_i.wr_en) begin
			mem_array[port_i.wr_addr] <= port_i.wr_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (port_i.rd_en) begin
			rd_data_ff <= mem_array[port_i.rd_addr];
		end
	end

	assign port_i.rd_data = rd_data_ff;
endmodule
`default_nettype wire

/* File: src/dof_mem_if.sv */
// line buffer port bundle between output stage and its memory
`default_nettype none
interface dof_mem_if #(
	parameter int DATA_W = 10,
	parameter int ADDR_W = 10
);
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic rd_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;

	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en,
		output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_en,
		input rd_addr, output rd_data);
endinterface
`default_nettype wire

/* File: src/dof_output_stage.sv */
// parallel output, error flag, status outputs and serial pin muxing
`default_nettype none
module dof_output_stage #(
	parameter int ERR_W = 8,
	parameter int DATA_W = 10,
	parameter int ADDR_W = 10
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_B_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [31:0] REG_RDATA_O,
	input wire logic [ERR_W-1:0] ERR_EVENT_I,
	input wire logic FRAME_START_I,
	input wire logic LOCKED_I,
	input wire logic [DATA_W-1:0] WORD_I,
	input wire logic WORD_VALID_I,
	input wire logic H_I,
	input wire logic V_I,
	input wire logic F_I,
	input wire logic ANCILLARY_PACKET_SEEN_I,
	input wire logic CHECK_PACKET_SEEN_I,
	input wire logic HOST_SDOUT_I,
	input wire logic SCAN_TDO_I,
	input wire logic RD_CLK_I,
	input wire logic RD_RESET_I,
	input wire logic SCAN_SELECT_I,
	input wire logic SERIAL_IN_PIN_I,
	input wire logic VIDEO_MODE_INDICATOR_I,
	input wire logic STREAM_MODE_I,
	output logic [DATA_W-1:0] DOUT_O,
	output logic PCLK_O,
	output logic ERROR_FLAG_B_O,
	output logic [3:0] STAT_O,
	output logic BUFFER_LOAD_FLAG_O,
	output logic SERIAL_OUT_PIN_O,
	output logic SERIAL_OUT_PIN_OE_O,
	output logic HOST_SDIN_O,
	output logic SCAN_TDI_O
);
	localparam int NPIN = 6;
	localparam int P_RDCLK = 0;
	localparam int P_RDRST = 1;
	localparam int P_SCAN = 2;
	localparam int P_SIN = 3;
	localparam int P_VMI = 4;
	localparam int P_STRM = 5;

	// ------------------------------------------------------------
	// reset release and pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_ff, pin_prev_ff;

	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	assign pin_raw = {STREAM_MODE_I, VIDEO_MODE_INDICATOR_I, SERIAL_IN_PIN_I,
		SCAN_SELECT_I, RD_RESET_I, RD_CLK_I};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
				if (!rst_n) begin
					pin_s1_ff[gi] <= 1'b0;
					pin_s2_ff[gi] <= 1'b0;
					pin_s3_ff[gi] <= 1'b0;
					pin_ff[gi] <= 1'b0;
					pin_prev_ff[gi] <= 1'b0;
				end else begin
					pin_s1_ff[gi] <= pin_raw[gi];
					pin_s2_ff[gi] <= pin_s1_ff[gi];
					pin_s3_ff[gi] <= pin_s2_ff[gi];
					// change accepted only once stages two and three agree
					if (pin_s2_ff[gi] == pin_s3_ff[gi]) begin
						pin_ff[gi] <= pin_s3_ff[gi];
					end
					pin_prev_ff[gi] <= pin_ff[gi];
				end
			end
		end
	endgenerate

	logic rd_clk_rise, rd_reset_fall;
	assign rd_clk_rise = pin_ff[P_RDCLK] & ~pin_prev_ff[P_RDCLK];
	assign rd_reset_fall = ~pin_ff[P_RDRST] & pin_prev_ff[P_RDRST];

	// ------------------------------------------------------------
	// pixel clock from a phase accumulator
	// ------------------------------------------------------------
	// 100 MHz cannot divide to 27 MHz evenly; edges jitter by one cycle
	localparam int PIX_ACC_W_L = dof_pkg::PIX_ACC_W;
	localparam logic [PIX_ACC_W_L-1:0] PIX_STEP = PIX_ACC_W_L'(dof_pkg::PIX_TOGGLE_STEP);
	localparam logic [PIX_ACC_W_L-1:0] PIX_MOD = PIX_ACC_W_L'(dof_pkg::SYS_CLK_MHZ);
	logic [PIX_ACC_W_L-1:0] pix_acc_ff, pix_sum;
	logic pclk_ff, pix_en;

	assign pix_sum = pix_acc_ff + PIX_STEP;
	assign pix_en = (pix_sum >= PIX_MOD) & ~pclk_ff;

	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			pix_acc_ff <= '0;
			pclk_ff <= 1'b0;
		end else if (pix_sum >= PIX_MOD) begin
			pix_acc_ff <= pix_sum - PIX_MOD;
			pclk_ff <= ~pclk_ff;
		end else begin
			pix_acc_ff <= pix_sum;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [ERR_W-1:0] err_status_ff, err_mask_ff;
	logic [31:0] io_cfg_ff;
	dof_pkg::dof_buf_mode_type buf_mode_ff;
	logic err_rd, err_flag_ff;
	logic full, empty;
	logic [ADDR_W:0] fill_ff;

	assign err_rd = REG_RD_I & (REG_ADDR_I == dof_pkg::ERR_STATUS_ADDR);

	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			err_mask_ff <= dof_pkg::ERR_MASK_RST[ERR_W-1:0];
			io_cfg_ff <= dof_pkg::IO_CFG_RST;
			buf_mode_ff <= dof_pkg::dof_buf_mode_type'(dof_pkg::BUF_CTRL_RST);
		end else if (REG_WR_I) begin
			case (REG_ADDR_I)
				dof_pkg::ERR_MASK_ADDR: err_mask_ff <= REG_WDATA_I[ERR_W-1:0];
				dof_pkg::IO_CFG_ADDR: io_cfg_ff <= REG_WDATA_I;
				dof_pkg::BUF_CTRL_ADDR: begin
					buf_mode_ff <= dof_pkg::dof_buf_mode_type'(
						REG_WDATA_I[dof_pkg::BUF_MODE_LSB +: 2]);
				end
				default: ;
			endcase
		end
	end

	// sticky record, cleared by read or frame start; new events win
	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			err_status_ff <= '0;
		end else if (err_rd | FRAME_START_I) begin
			err_status_ff <= ERR_EVENT_I;
		end else begin
			err_status_ff <= err_status_ff | ERR_EVENT_I;
		end
	end

	// flag sampled on pixel rate; the read clear reaches it via the record
	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			err_flag_ff <= 1'b1;
		end else if (pix_en) begin
			err_flag_ff <= ~|(err_status_ff & err_mask_ff);
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			REG_RDATA_O <= '0;
		end else if (REG_RD_I) begin
			case (REG_ADDR_I)
				dof_pkg::ERR_STATUS_ADDR: REG_RDATA_O <= 32'(err_status_ff);
				dof_pkg::ERR_MASK_ADDR: REG_RDATA_O <= 32'(err_mask_ff);
				dof_pkg::IO_CFG_ADDR: REG_RDATA_O <= io_cfg_ff;
				dof_pkg::BUF_CTRL_ADDR: REG_RDATA_O <= 32'(buf_mode_ff);
				dof_pkg::STATUS_ADDR: begin
					REG_RDATA_O <= (32'(fill_ff) << dof_pkg::STATUS_FILL_LSB)
						| (32'(err_flag_ff) << dof_pkg::STATUS_FLAG_BIT)
						| (32'(empty) << dof_pkg::STATUS_EMPTY_BIT)
						| (32'(full) << dof_pkg::STATUS_FULL_BIT)
						| (32'(LOCKED_I) << dof_pkg::STATUS_LOCK_BIT);
				end
				default: REG_RDATA_O <= '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// line buffer
	// ------------------------------------------------------------
	dof_mem_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) mem_bus ();
	logic [ADDR_W-1:0] wr_ptr_ff, rd_ptr_ff;
	logic buffered, ptr_reset_ok, wr_go, rd_go, rd_pend_ff;

	assign buffered = (buf_mode_ff != dof_pkg::BUF_BYPASS);
	assign full = (fill_ff == (ADDR_W+1)'(1 << ADDR_W));
	assign empty = (fill_ff == '0);
	assign wr_go = buffered & WORD_VALID_I & ~full;
	// one word per read clock rise
	assign rd_go = buffered & rd_clk_rise & ~empty;
	// pointer reset only in video buffer mode with video stream
	assign ptr_reset_ok = (buf_mode_ff == dof_pkg::BUF_VIDEO) & pin_ff[P_VMI] & ~pin_ff[P_STRM];

	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			fill_ff <= '0;
		end else if (!buffered) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			fill_ff <= '0;
		end else begin
			if (wr_go) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			// falling edge returns read address zero
			if (ptr_reset_ok & rd_reset_fall) begin
				rd_ptr_ff <= '0;
				fill_ff <= (ADDR_W+1)'(wr_ptr_ff) + (ADDR_W+1)'(wr_go);
			end else begin
				if (rd_go) begin
					rd_ptr_ff <= rd_ptr_ff + 1'b1;
				end
				fill_ff <= fill_ff + (ADDR_W+1)'(wr_go) - (ADDR_W+1)'(rd_go);
			end
		end
	end

	assign mem_bus.wr_en = wr_go;
	assign mem_bus.wr_addr = wr_ptr_ff;
	assign mem_bus.wr_data = WORD_I;
	assign mem_bus.rd_en = rd_go;
	assign mem_bus.rd_addr = rd_ptr_ff;

	dof_line_mem #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_mem (
		.clk_i(CLK_SYS_I),
		.port_i(mem_bus.mem)
	);

	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			rd_pend_ff <= 1'b0;
		end else begin
			rd_pend_ff <= rd_go;
		end
	end

	// ------------------------------------------------------------
	// parallel output
	// ------------------------------------------------------------
	logic [DATA_W-1:0] word_hold_ff;

	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			word_hold_ff <= '0;
		end else if (WORD_VALID_I) begin
			word_hold_ff <= WORD_I;
		end
	end

	// bit 9 msb; lock low forces zero
	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			DOUT_O <= '0;
		end else if (!LOCKED_I) begin
			DOUT_O <= '0;
		end else if (buffered) begin
			// buffered word two cycles after read clock rise
			if (rd_pend_ff) begin
				DOUT_O <= mem_bus.rd_data;
			end
		end else if (pclk_ff & ~PCLK_O) begin
			// bypass word moves on the edge that raises PCLK_O
			DOUT_O <= word_hold_ff;
		end
	end

	// ------------------------------------------------------------
	// status outputs
	// ------------------------------------------------------------
	logic load_flag;
	logic [7:0] src_vec;
	assign load_flag = wr_go & (wr_ptr_ff == '0);
	assign src_vec = {empty, full, CHECK_PACKET_SEEN_I, ANCILLARY_PACKET_SEEN_I,
		load_flag, F_I, V_I, H_I};

	// defaults per buffer mode and output index
	function automatic logic [2:0] default_sel(input dof_pkg::dof_buf_mode_type m,
		input int idx);
		logic [11:0] tbl;
		tbl = 12'h000;
		case (m)
			dof_pkg::BUF_VIDEO: tbl = {dof_pkg::SEL_LOAD, dof_pkg::SEL_F,
				dof_pkg::SEL_V, dof_pkg::SEL_H};
			dof_pkg::BUF_STREAM: tbl = {dof_pkg::SEL_CHECK, dof_pkg::SEL_EMPTY,
				dof_pkg::SEL_FULL, dof_pkg::SEL_LOAD};
			default: tbl = {dof_pkg::SEL_ANC, dof_pkg::SEL_F,
				dof_pkg::SEL_V, dof_pkg::SEL_H};
		endcase
		default_sel = tbl[idx*dof_pkg::STAT_SEL_W +: dof_pkg::STAT_SEL_W];
	endfunction

	generate
		for (gi = 0; gi < 4; gi++) begin : g_stat
			logic [2:0] sel;
			assign sel = io_cfg_ff[dof_pkg::IO_CFG_OVR_BIT]
				? io_cfg_ff[gi*dof_pkg::STAT_SEL_W +: dof_pkg::STAT_SEL_W]
				: default_sel(buf_mode_ff, gi);
			always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
				if (!rst_n) begin
					STAT_O[gi] <= 1'b0;
				end else begin
					STAT_O[gi] <= LOCKED_I & src_vec[sel];
				end
			end
		end
	endgenerate

	// remaining outputs forced low without lock
	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			PCLK_O <= 1'b0;
			ERROR_FLAG_B_O <= 1'b1;
			BUFFER_LOAD_FLAG_O <= 1'b0;
		end else begin
			PCLK_O <= LOCKED_I & pclk_ff;
			ERROR_FLAG_B_O <= LOCKED_I & err_flag_ff;
			BUFFER_LOAD_FLAG_O <= LOCKED_I & load_flag;
		end
	end

	// ------------------------------------------------------------
	// shared serial pins
	// ------------------------------------------------------------
	// select steers serial pins to scan or host
	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			SERIAL_OUT_PIN_O <= 1'b0;
			SERIAL_OUT_PIN_OE_O <= 1'b0;
			HOST_SDIN_O <= 1'b0;
			SCAN_TDI_O <= 1'b0;
		end else begin
			SERIAL_OUT_PIN_O <= pin_ff[P_SCAN] ? SCAN_TDO_I : HOST_SDOUT_I;
			SERIAL_OUT_PIN_OE_O <= 1'b1;
			HOST_SDIN_O <= ~pin_ff[P_SCAN] & pin_ff[P_SIN];
			SCAN_TDI_O <= pin_ff[P_SCAN] & pin_ff[P_SIN];
		end
	end
endmodule
`default_nettype wire

/* File: src/dof_pkg.sv */
// constants shared by the deserializer output stage
`default_nettype none
package dof_pkg;
	// register byte offsets
	localparam logic [7:0] ERR_STATUS_ADDR = 8'h00;
	localparam logic [7:0] ERR_MASK_ADDR = 8'h04;
	localparam logic [7:0] IO_CFG_ADDR = 8'h08;
	localparam logic [7:0] BUF_CTRL_ADDR = 8'h0c;
	localparam logic [7:0] STATUS_ADDR = 8'h10;
	// field positions
	localparam int STAT_SEL_W = 3;
	localparam int IO_CFG_OVR_BIT = 12;
	localparam int BUF_MODE_LSB = 0;
	localparam int STATUS_LOCK_BIT = 0;
	localparam int STATUS_FULL_BIT = 1;
	localparam int STATUS_EMPTY_BIT = 2;
	localparam int STATUS_FLAG_BIT = 3;
	localparam int STATUS_FILL_LSB = 8;
	// reset values
	localparam logic [31:0] ERR_MASK_RST = 32'hffffffff;
	localparam logic [31:0] IO_CFG_RST = 32'h00000000;
	localparam logic [1:0] BUF_CTRL_RST = 2'h0;
	// timing: system clock and pixel clock in MHz
	localparam int SYS_CLK_MHZ = 100;
	localparam int PIX_CLK_MHZ = 27;
	localparam int PIX_TOGGLE_STEP = 2 * PIX_CLK_MHZ;
	localparam int PIX_ACC_W = 8;
	// pin synchroniser depth
	localparam int SYNC_STAGES = 3;

	typedef enum logic [1:0] {
		BUF_BYPASS = 2'b00,
		BUF_VIDEO = 2'b01,
		BUF_STREAM = 2'b10
	} dof_buf_mode_type;

	typedef enum logic [2:0] {
		SEL_H = 3'b000,
		SEL_V = 3'b001,
		SEL_F = 3'b010,
		SEL_LOAD = 3'b011,
		SEL_ANC = 3'b100,
		SEL_CHECK = 3'b101,
		SEL_FULL = 3'b110,
		SEL_EMPTY = 3'b111
	} dof_stat_sel_type;
endpackage
`default_nettype wire
